// [hdl/mca_pkg.sv]
// How it works
// - Aux code 0000b unused, 0010b reserved, 0101b laser wavelength.
// - Aux code 0001b: result is photodiode bias voltage, 10mV per count.
// - Aux code 0011b: result is cooler current, 0.1mA per count.
// - Aux code 0100b: result uses signed module temperature encoding.
// - Aux codes 0110b-1001b: supply voltages encoded like primary supply.
// - Aux codes 1010b,1101b-1111b: supply currents, 0.1mA per count.
// - Unmasked threshold crossing sets alarm or warning flag and interrupt.
// - Diode or bias-set crossing raises safety fault, gate, shutdown at once.
// - Factory gain gives 38.147uV per count on power and bias channels.
// - Supply and aux voltage results are unsigned, 100uV per count.
// - Temperature is two's complement, whole degrees high, 1/256 low.
// - Temp offset only; supply gain and offset; others also shift, except signed aux results.
// - Largest unsigned result is FFF8h shifted right by the shift count (supply unshifted); signed tops at 7FF8h.
// - Nonzero shift moves unsigned non-supply results right before they are stored.
// - Flags latch on first excursion, clear when their location is read.
package mca_pkg;
    localparam int NCH = 8;
    localparam int NALM = 6;
    localparam int NFLAG = 25;
    localparam int FAULT_BIT = 24;
    localparam int GAIN_SHIFT = 15;
    // Channel numbers on the converter side
    localparam logic [2:0] CH_TEMP = 3'h0;
    localparam logic [2:0] CH_SUPPLY = 3'h1;
    localparam logic [2:0] CH_BIAS = 3'h2;
    localparam logic [2:0] CH_RXPWR = 3'h3;
    localparam logic [2:0] CH_AUX1 = 3'h4;
    localparam logic [2:0] CH_AUX2 = 3'h5;
    localparam logic [2:0] CH_BMD = 3'h6;
    localparam logic [2:0] CH_BSET = 3'h7;
    // Aux unit codes
    localparam logic [3:0] UNIT_UNUSED = 4'h0;
    localparam logic [3:0] UNIT_RSVD = 4'h2;
    localparam logic [3:0] UNIT_LTEMP = 4'h4;
    localparam logic [3:0] UNIT_NOCODE_A = 4'hB;
    localparam logic [3:0] UNIT_NOCODE_B = 4'hC;
    // Result kinds
    localparam logic [1:0] KIND_OFF = 2'h0;
    localparam logic [1:0] KIND_UNS = 2'h1;
    localparam logic [1:0] KIND_SGN = 2'h2;
    // Clamp limits
    localparam logic [15:0] U_MAX = 16'hFFF8;
    localparam logic [15:0] S_MAX = 16'h7FF8;
    localparam logic [15:0] S_MIN = 16'h8800;
    // Register byte offsets
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_MASK = 12'h008;
    localparam logic [11:0] ADDR_FAULT = 12'h00C;
    localparam logic [11:0] ADDR_FMASK = 12'h010;
    localparam logic [11:0] BASE_GAIN = 12'h040;
    localparam logic [11:0] BASE_OFFSET = 12'h060;
    localparam logic [11:0] BASE_SHIFT = 12'h080;
    localparam logic [11:0] BASE_RESULT = 12'h0A0;
    localparam logic [11:0] BASE_THR = 12'h100;
    // Reset values; unity gain keeps the factory weighting
    localparam logic [15:0] GAIN_RST = 16'h8000;
    localparam logic [15:0] OFFSET_RST = 16'h0000;
    localparam logic [3:0] SHIFT_RST = 4'h0;
    localparam logic [15:0] THR_RST = 16'h0000;
    localparam logic [24:0] MASK_RST = 25'h1FFFFFF;
    localparam logic [2:0] FMASK_RST = 3'h7;
    localparam logic [3:0] AUX_RST = 4'h0;
endpackage

// [hdl/mca_top.sv]
`timescale 1ns/1ps
module mca_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sample_valid,
    input wire logic [2:0] sample_chan,
    input wire logic [15:0] sample_data,
    output logic interrupt,
    output logic laser_gate_output,
    output logic laser_shutdown
);
    typedef struct packed {
        logic vld_s1;
        logic vld_s2;
        logic vld_s3;
        logic [15:0] dat_s1;
        logic [15:0] dat_s2;
        logic [2:0] ch_s1;
        logic [2:0] ch_s2;
        logic [7:0][15:0] gain;
        logic [7:0][15:0] offset;
        logic [7:0][15:0] result;
        logic [7:0][3:0] shift;
        logic [5:0][3:0][15:0] thr;
        logic [2:0][15:0] safe_thr;
        logic [1:0][3:0] aux_unit;
        logic [24:0] status;
        logic [24:0] mask;
        logic fault;
        logic [2:0] fault_mask;
        logic irq;
        logic [31:0] prdata;
    } mca_state_t;

    mca_state_t state;
    mca_state_t next_state;

    logic samp;
    logic [2:0] ch;
    logic [1:0] kind;
    logic sgn;
    logic g_en;
    logic sh_en;
    logic [15:0] cal_val;
    logic [24:0] set;
    logic [24:0] clr;
    logic fault_hit;
    logic fclr;
    logic hit;
    logic wr;
    logic rd;
    logic [2:0] idx;
    logic [31:0] rdata;
    logic in_gain;
    logic in_off;
    logic in_shift;
    logic in_res;
    logic in_thr;
    logic in_safe;

    // Which encoding an aux unit code selects
    function automatic logic [1:0] aux_kind(input logic [3:0] code);
        if (code == mca_pkg::UNIT_UNUSED || code == mca_pkg::UNIT_NOCODE_A ||
            code == mca_pkg::UNIT_NOCODE_B) begin
            return mca_pkg::KIND_OFF;
        end else if (code == mca_pkg::UNIT_LTEMP) begin
            return mca_pkg::KIND_SGN;
        end
        return mca_pkg::KIND_UNS;
    endfunction

    // Greater-than in the encoding of the channel
    function automatic logic cmp_gt(input logic [15:0] a,
                                    input logic [15:0] b,
                                    input logic sgn);
        return sgn ? ($signed(a) > $signed(b)) : (a > b);
    endfunction

    // Gain, offset, clamp, then shift
    function automatic logic [15:0] cal(input logic [15:0] raw, gain, offs,
                                        input logic [3:0] sh,
                                        input logic sgn, g_en, sh_en);
        logic [31:0] prod;
        logic signed [33:0] acc;
        logic [15:0] v;
        prod = raw * gain;
        if (g_en) begin
            acc = $signed({2'b00, prod}) >>> mca_pkg::GAIN_SHIFT;
        end else if (sgn) begin
            acc = $signed({{18{raw[15]}}, raw});
        end else begin
            acc = $signed({18'h00000, raw});
        end
        // Offset register holds a quarter of the correction
        acc = acc + $signed({{16{offs[15]}}, offs, 2'b00});
        if (sgn) begin
            if (acc > $signed({18'h00000, mca_pkg::S_MAX})) begin
                v = mca_pkg::S_MAX;
            end else if (acc < $signed({{18{1'b1}}, mca_pkg::S_MIN})) begin
                v = mca_pkg::S_MIN;
            end else begin
                v = acc[15:0];
            end
        end else begin
            if (acc < 0) begin
                v = 16'h0000;
            end else if (acc > $signed({18'h00000, mca_pkg::U_MAX})) begin
                v = mca_pkg::U_MAX;
            end else begin
                v = acc[15:0];
            end
            v = sh_en ? v >> sh : v;
        end
        return v;
    endfunction

    // Region decode of the register map
    always_comb begin
        idx = paddr[4:2];
        in_gain = paddr[11:5] == mca_pkg::BASE_GAIN[11:5];
        in_off = paddr[11:5] == mca_pkg::BASE_OFFSET[11:5];
        in_shift = paddr[11:5] == mca_pkg::BASE_SHIFT[11:5];
        in_res = paddr[11:5] == mca_pkg::BASE_RESULT[11:5];
        in_thr = paddr[11:7] == mca_pkg::BASE_THR[11:7] &&
                 paddr[6:4] < 3'h6;
        in_safe = paddr[11:7] == mca_pkg::BASE_THR[11:7] &&
                  paddr[6:4] == 3'h6 && paddr[3:2] < 2'h3;
        hit = in_gain || in_off || in_shift || in_res || in_thr ||
              in_safe || paddr == mca_pkg::ADDR_CTRL ||
              paddr == mca_pkg::ADDR_STATUS ||
              paddr == mca_pkg::ADDR_MASK ||
              paddr == mca_pkg::ADDR_FAULT ||
              paddr == mca_pkg::ADDR_FMASK;
        wr = psel && penable && pwrite;
        rd = psel && penable && !pwrite;
    end

    // Read data, captured in the setup phase
    always_comb begin
        rdata = 32'h00000000;
        if (in_gain) begin
            rdata[15:0] = state.gain[idx];
        end else if (in_off) begin
            rdata[15:0] = state.offset[idx];
        end else if (in_shift) begin
            rdata[3:0] = state.shift[idx];
        end else if (in_res) begin
            rdata[15:0] = state.result[idx];
        end else if (in_thr) begin
            rdata[15:0] = state.thr[paddr[6:4]][paddr[3:2]];
        end else if (in_safe) begin
            rdata[15:0] = state.safe_thr[paddr[3:2]];
        end else begin
            case (paddr)
                mca_pkg::ADDR_CTRL: begin
                    rdata[7:0] = {state.aux_unit[1], state.aux_unit[0]};
                end
                mca_pkg::ADDR_STATUS: begin
                    rdata[24:0] = state.status;
                end
                mca_pkg::ADDR_MASK: begin
                    rdata[24:0] = state.mask;
                end
                mca_pkg::ADDR_FAULT: begin
                    rdata[0] = state.fault;
                end
                mca_pkg::ADDR_FMASK: begin
                    rdata[2:0] = state.fault_mask;
                end
                default: begin
                    rdata = 32'h00000000;
                end
            endcase
        end
    end

    // Channel encoding and calibration of the arriving sample
    always_comb begin
        samp = state.vld_s2 && !state.vld_s3;
        ch = state.ch_s2;
        case (ch)
            mca_pkg::CH_TEMP: kind = mca_pkg::KIND_SGN;
            mca_pkg::CH_AUX1: kind = aux_kind(state.aux_unit[0]);
            mca_pkg::CH_AUX2: kind = aux_kind(state.aux_unit[1]);
            default: kind = mca_pkg::KIND_UNS;
        endcase
        sgn = kind == mca_pkg::KIND_SGN;
        g_en = ch != mca_pkg::CH_TEMP;
        sh_en = ch != mca_pkg::CH_TEMP && ch != mca_pkg::CH_SUPPLY;
        if (kind == mca_pkg::KIND_OFF) begin
            cal_val = 16'h0000;
        end else begin
            cal_val = cal(state.dat_s2, state.gain[ch], state.offset[ch],
                          state.shift[ch], sgn, g_en, sh_en);
        end
    end

    // Next state: synchronisers, results, flags, fault, bus writes
    always_comb begin
        next_state = state;
        set = '0;
        clr = '0;
        fault_hit = 1'b0;
        fclr = 1'b0;
        // Converter signals cross in from another domain
        next_state.vld_s1 = sample_valid;
        next_state.vld_s2 = state.vld_s1;
        next_state.vld_s3 = state.vld_s2;
        next_state.dat_s1 = sample_data;
        next_state.dat_s2 = state.dat_s1;
        next_state.ch_s1 = sample_chan;
        next_state.ch_s2 = state.ch_s1;
        if (samp) begin
            next_state.result[ch] = cal_val;
            if (kind != mca_pkg::KIND_OFF && ch < 3'h6) begin
                // Even slots trip high, odd slots trip low
                for (int k = 0; k < 4; k++) begin
                    if (k[0] ? cmp_gt(state.thr[ch][k], cal_val, sgn)
                              : cmp_gt(cal_val, state.thr[ch][k], sgn)) begin
                        set[{ch, 2'(k)}] = !state.mask[{ch, 2'(k)}];
                    end
                end
            end
            if (ch == mca_pkg::CH_BMD) begin
                fault_hit = (cal_val > state.safe_thr[0] &&
                             !state.fault_mask[0]) ||
                            (cal_val < state.safe_thr[1] &&
                             !state.fault_mask[1]);
            end
            if (ch == mca_pkg::CH_BSET) begin
                fault_hit = cal_val > state.safe_thr[2] &&
                            !state.fault_mask[2];
            end
        end
        set[mca_pkg::FAULT_BIT] = fault_hit &&
                                  !state.mask[mca_pkg::FAULT_BIT];
        if (psel && !penable) begin
            next_state.prdata = rdata;
        end
        // Only the bits the host actually saw are cleared
        if (rd && paddr == mca_pkg::ADDR_STATUS) begin
            clr = state.prdata[24:0];
        end
        if (wr) begin
            if (in_gain) begin
                next_state.gain[idx] = pwdata[15:0];
            end else if (in_off) begin
                next_state.offset[idx] = pwdata[15:0];
            end else if (in_shift) begin
                next_state.shift[idx] = pwdata[3:0];
            end else if (in_thr) begin
                next_state.thr[paddr[6:4]][paddr[3:2]] = pwdata[15:0];
            end else if (in_safe) begin
                next_state.safe_thr[paddr[3:2]] = pwdata[15:0];
            end else begin
                case (paddr)
                    mca_pkg::ADDR_CTRL: begin
                        next_state.aux_unit[0] = pwdata[3:0];
                        next_state.aux_unit[1] = pwdata[7:4];
                    end
                    mca_pkg::ADDR_STATUS: clr = clr | pwdata[24:0];
                    mca_pkg::ADDR_MASK: next_state.mask = pwdata[24:0];
                    mca_pkg::ADDR_FAULT: fclr = pwdata[0];
                    mca_pkg::ADDR_FMASK: begin
                        next_state.fault_mask = pwdata[2:0];
                    end
                    default: begin
                    end
                endcase
            end
        end
        // A new event wins over a clear in the same cycle
        next_state.status = (state.status & ~clr) | set;
        next_state.fault = (state.fault && !fclr) || fault_hit;
        next_state.irq = |(next_state.status & ~next_state.mask);
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0;
            state.gain <= {mca_pkg::NCH{mca_pkg::GAIN_RST}};
            state.offset <= {mca_pkg::NCH{mca_pkg::OFFSET_RST}};
            state.shift <= {mca_pkg::NCH{mca_pkg::SHIFT_RST}};
            state.thr <= {(mca_pkg::NALM * 4){mca_pkg::THR_RST}};
            state.safe_thr <= {3{mca_pkg::THR_RST}};
            state.aux_unit <= {2{mca_pkg::AUX_RST}};
            state.mask <= mca_pkg::MASK_RST;
            state.fault_mask <= mca_pkg::FMASK_RST;
        end else begin
            state <= next_state;
        end
    end

    // Zero-wait slave; gate follows the fault flop directly
    assign prdata = state.prdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign interrupt = state.irq;
    assign laser_gate_output = state.fault;
    assign laser_shutdown = state.fault;

    sequence gate_no_clr;
        laser_gate_output && !(psel && penable && pwrite &&
        paddr == mca_pkg::ADDR_FAULT && pwdata[0]);
    endsequence

    sequence status_rd;
        psel && penable && !pwrite && paddr == mca_pkg::ADDR_STATUS;
    endsequence

    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        interrupt == |(state.status & ~state.mask))
        else $error("interrupt does not match unmasked status");

    a_mask_blocks_set: assert property (@(posedge pclk)
        disable iff (!presetn) (set & state.mask) == 25'h0000000)
        else $error("masked flag was set");

    a_fault_trips_gate: assert property (@(posedge pclk)
        disable iff (!presetn)
        samp && ch == mca_pkg::CH_BSET && !state.fault_mask[2] &&
        cal_val > state.safe_thr[2] |=> laser_gate_output && laser_shutdown)
        else $error("bias-set trip did not assert the gate");

    a_fault_sticky: assert property (@(posedge pclk)
        disable iff (!presetn) gate_no_clr |=> laser_gate_output)
        else $error("gate dropped without a clear");

    a_clamp_limit: assert property (@(posedge pclk)
        disable iff (!presetn) samp && !sgn && sh_en |->
        cal_val <= (mca_pkg::U_MAX >> state.shift[ch]))
        else $error("result above shifted clamp");

    a_result_store: assert property (@(posedge pclk)
        disable iff (!presetn) samp |=>
        state.result[$past(ch)] == $past(cal_val))
        else $error("result register not updated");

    a_temp_range: assert property (@(posedge pclk)
        disable iff (!presetn) samp && ch == mca_pkg::CH_TEMP |->
        $signed(cal_val) <= $signed(mca_pkg::S_MAX) &&
        $signed(cal_val) >= $signed(mca_pkg::S_MIN))
        else $error("temperature outside signed range");

    a_aux_unused: assert property (@(posedge pclk)
        disable iff (!presetn) samp && ch == mca_pkg::CH_AUX1 &&
        state.aux_unit[0] == mca_pkg::UNIT_UNUSED |=>
        state.result[4] == 16'h0000)
        else $error("unused aux channel reported a value");

    a_read_clears: assert property (@(posedge pclk)
        disable iff (!presetn) status_rd ##0 (set == 25'h0000000) |=>
        (state.status & $past(state.prdata[24:0])) == 25'h0000000)
        else $error("read flag did not clear");
endmodule

// [sim/mca_conv_model.sv]
`timescale 1ns/1ps
module mca_conv_model (
    input wire logic pclk,
    output logic sample_valid,
    output logic [2:0] sample_chan,
    output logic [15:0] sample_data
);
    // Idle converter: strobe low, fields parked
    initial begin
        sample_valid = 1'b0;
        sample_chan = 3'h0;
        sample_data = 16'h0000;
    end

    // One conversion; fields hold 3 cycles either side of the 4-cycle strobe pulse
    task automatic convert(input logic [2:0] ch, input logic [15:0] d);
        sample_chan <= ch;
        sample_data <= d;
        repeat (3) @(posedge pclk);
        sample_valid <= 1'b1;
        repeat (4) @(posedge pclk);
        sample_valid <= 1'b0;
        repeat (3) @(posedge pclk);
        // Hold time is over, so show junk rather than the old value
        sample_chan <= ~ch;
        sample_data <= ~d;
        repeat (3) @(posedge pclk);
    endtask
endmodule

// [sim/tb_monitor_calibration_alarm.sv]
`timescale 1ns/1ps
module tb_monitor_calibration_alarm;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sample_valid;
    logic [2:0] sample_chan;
    logic [15:0] sample_data;
    logic interrupt;
    logic laser_gate_output;
    logic laser_shutdown;
    int error_cnt = 0;
    int samples_checked = 0;
    int cyc = 0;
    logic [31:0] rd;
    logic er;

    always #2.5 pclk = ~pclk;

    mca_top i_mca_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample_valid(sample_valid), .sample_chan(sample_chan),
        .sample_data(sample_data), .interrupt(interrupt),
        .laser_gate_output(laser_gate_output),
        .laser_shutdown(laser_shutdown));

    mca_conv_model i_mca_conv_model (.pclk(pclk),
        .sample_valid(sample_valid), .sample_chan(sample_chan),
        .sample_data(sample_data));

    task automatic conclude();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // A hang must still reach the verdict
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            conclude();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; request held until pready seen high
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(rd, exp);
    endtask

    // Reads the three level outputs away from the clock edge
    task automatic peek(input logic [2:0] exp);
        @(negedge pclk);
        chk({29'h0, interrupt, laser_gate_output, laser_shutdown},
            {29'h0, exp});
        @(posedge pclk);
    endtask

    function automatic logic [11:0] res(input logic [2:0] ch);
        return mca_pkg::BASE_RESULT + {7'h00, ch, 2'b00};
    endfunction

    task automatic t_reset_values();
        rchk(mca_pkg::BASE_GAIN, 32'h00008000);
        rchk(mca_pkg::ADDR_MASK, 32'h01FFFFFF);
        rchk(mca_pkg::ADDR_CTRL, 32'h00000000);
        apb(1'b1, res(3'h1), 32'h0000ABCD);
        rchk(res(3'h1), 32'h00000000);
        apb(1'b0, 12'h200, 32'h00000000);
        chk({31'h0, er}, 32'h00000001);
        chk(rd, 32'h00000000);
    endtask

    // Supply: gain and offset, shift ignored; bias: shift after clamp
    task automatic t_calibration();
        apb(1'b1, mca_pkg::BASE_GAIN + 12'h004, 32'h00004000);
        apb(1'b1, mca_pkg::BASE_OFFSET + 12'h004, 32'h00000010);
        apb(1'b1, mca_pkg::BASE_SHIFT + 12'h004, 32'h00000002);
        i_mca_conv_model.convert(3'h1, 16'h1234);
        rchk(res(3'h1), 32'h0000091A + 32'h00000040);
        apb(1'b1, mca_pkg::BASE_SHIFT + 12'h008, 32'h00000002);
        i_mca_conv_model.convert(3'h2, 16'hFFFF);
        rchk(res(3'h2), 32'h0000FFF8 >> 2);
        // Offset is minus the null reading over four
        apb(1'b1, mca_pkg::BASE_OFFSET + 12'h00C, 32'h0000FFC0);
        i_mca_conv_model.convert(3'h3, 16'h0100);
        rchk(res(3'h3), 32'h00000000);
        i_mca_conv_model.convert(3'h3, 16'h0080);
        rchk(res(3'h3), 32'h00000000);
    endtask

    // Gain by binary search on the power channel, then null offset
    task automatic t_gain_search();
        logic [15:0] g;
        logic [15:0] m1;
        logic [15:0] m2;
        g = 16'h0000;
        apb(1'b1, mca_pkg::BASE_OFFSET + 12'h00C, 32'h00000000);
        for (int n = 15; n >= 0; n--) begin
            g[n] = 1'b1;
            apb(1'b1, mca_pkg::BASE_GAIN + 12'h00C, {16'h0000, g});
            i_mca_conv_model.convert(3'h3, 16'h9000);
            apb(1'b0, res(3'h3), 32'h00000000);
            m2 = rd[15:0];
            i_mca_conv_model.convert(3'h3, 16'h1000);
            apb(1'b0, res(3'h3), 32'h00000000);
            m1 = rd[15:0];
            // Trial bit stays only below the clamp and within the span
            if (m2 >= mca_pkg::U_MAX || m2 - m1 > 16'h4000) begin
                g[n] = 1'b0;
            end
        end
        apb(1'b1, mca_pkg::BASE_GAIN + 12'h00C, {16'h0000, g});
        rchk(mca_pkg::BASE_GAIN + 12'h00C, 32'h00004000);
        i_mca_conv_model.convert(3'h3, 16'h1000);
        apb(1'b0, res(3'h3), 32'h00000000);
        m1 = rd[15:0];
        apb(1'b1, mca_pkg::BASE_OFFSET + 12'h00C,
            {16'h0000, 16'h0000 - (m1 >> 2)});
        i_mca_conv_model.convert(3'h3, 16'h1000);
        rchk(res(3'h3), 32'h00000000);
        i_mca_conv_model.convert(3'h3, 16'h9000);
        rchk(res(3'h3), 32'h00004000);
    endtask

    // Temperature: offset only, signed clamps
    task automatic t_temperature();
        apb(1'b1, mca_pkg::BASE_GAIN, 32'h00004000);
        i_mca_conv_model.convert(3'h0, 16'hF600);
        rchk(res(3'h0), 32'h0000F600);
        i_mca_conv_model.convert(3'h0, 16'h7FFF);
        rchk(res(3'h0), 32'h00007FF8);
        i_mca_conv_model.convert(3'h0, 16'h8000);
        rchk(res(3'h0), 32'h00008800);
    endtask

    // Every unit code on both aux channels
    task automatic t_aux_units();
        logic [15:0] e;
        for (int c = 0; c < 16; c++) begin
            apb(1'b1, mca_pkg::ADDR_CTRL, {24'h0, 4'(c), 4'(c)});
            if (c == 0 || c == 11 || c == 12) begin
                e = 16'h0000;
            end else if (c == 4) begin
                e = 16'h7FF8;
            end else begin
                e = 16'h7FFF;
            end
            i_mca_conv_model.convert(3'h4, 16'h7FFF);
            rchk(res(3'h4), {16'h0, e});
            i_mca_conv_model.convert(3'h5, 16'h7FFF);
            rchk(res(3'h5), {16'h0, e});
        end
    endtask

    // Supply high alarm: masked, latched, cleared by read and by write
    task automatic t_alarm();
        apb(1'b1, mca_pkg::BASE_THR + 12'h010, 32'h00001000);
        i_mca_conv_model.convert(3'h1, 16'h4000);
        rchk(mca_pkg::ADDR_STATUS, 32'h00000000);
        apb(1'b1, mca_pkg::ADDR_MASK, 32'h01FFFFEF);
        i_mca_conv_model.convert(3'h1, 16'h4000);
        peek(3'b100);
        rchk(mca_pkg::ADDR_STATUS, 32'h00000010);
        rchk(mca_pkg::ADDR_STATUS, 32'h00000000);
        peek(3'b000);
        i_mca_conv_model.convert(3'h1, 16'h4000);
        apb(1'b1, mca_pkg::ADDR_STATUS, 32'h00000010);
        rchk(mca_pkg::ADDR_STATUS, 32'h00000000);
    endtask

    // Diode and bias-set trips drive gate and shutdown
    task automatic t_fault();
        apb(1'b1, 12'h160, 32'h00001000);
        apb(1'b1, mca_pkg::ADDR_FMASK, 32'h00000006);
        i_mca_conv_model.convert(3'h6, 16'h2000);
        peek(3'b011);
        rchk(mca_pkg::ADDR_FAULT, 32'h00000001);
        apb(1'b1, mca_pkg::ADDR_FAULT, 32'h00000001);
        peek(3'b000);
        apb(1'b1, 12'h168, 32'h00001000);
        apb(1'b1, mca_pkg::ADDR_FMASK, 32'h00000003);
        i_mca_conv_model.convert(3'h7, 16'h3000);
        peek(3'b011);
    endtask

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset_values();
        t_calibration();
        t_gain_search();
        t_temperature();
        t_aux_units();
        t_alarm();
        t_fault();
        conclude();
    end
endmodule
